//--- logic/host_bus_ready_decode_regs.svh
// Purpose: named constants of the host bus ready and decode block
// Assumes: included by bare name; guard prevents double inclusion
// Notes: widths, field positions, thresholds, reset values and fixed values only
//
// Behaviour
// - strap low selects local-bus mode, else burst-DMA mode, for synchronous cycles
// - strap never changes asynchronous ready behaviour
// - async ready release edge is timed by the internal oscillator clock
// - async ready held off while the no-wait bit is cleared
// - async read waits while read fifo holds fewer than 4 bytes
// - async write waits while write fifo is full
// - local-bus mode: sync ready idles high, pulses low on bus clock to complete
// - burst mode: ready-return sampled on falling bus clock, reads wait for high
// - single interrupt output raised on any enabled status event
// - old interrupt-line select bits are reserved and ignored
// - local-device hit when qualifier low and upper address matches base high byte
// - local-device hit is combinational from unlatched address and qualifier
// - data-path select low grants packet data access regardless of address
// - data-path select transfers are 32 bits wide, bursts both ways
// - synchronous cycle is a write when direction is high, else a read
// - byte enables ignored while data-path select is low
// - address and qualifier latched on rising edge of the address strobe
// - address decoding enabled only while qualifier is low
`ifndef HOST_BUS_READY_DECODE_REGS_SVH
`define HOST_BUS_READY_DECODE_REGS_SVH

// ****************************************************************
// widths and fields
// ****************************************************************
`define UPPER_ADDR_W      12
`define LANE_W            4
`define BASE_HI_W         8
`define BASE_MATCH_HI     11
`define BASE_MATCH_LO     4
`define RD_FIFO_MIN_BYTES 4

// ****************************************************************
// reset and fixed values
// ****************************************************************
`define SRDY_N_RST        1'b1
`define LANES_ALL_ON_N    4'h0
`define LANES_RST_N       4'hf
`define ADDR_RST          12'h000
`define OD_LOW_LEVEL      1'b0

`endif

//--- logic/host_bus_ready_decode_pkg.sv
// Purpose: types shared by the host bus ready and decode block
// Assumes: constants come from the _regs header
// Notes: used only through scoped names
`include "host_bus_ready_decode_regs.svh"

package host_bus_ready_decode_pkg;

  // ****************************************************************
  // pins that cross into the clk domain
  // ****************************************************************
  typedef struct packed {
    logic                       addrLatchStrobeN;
    logic                       hostBusClock;
    logic                       readStrobeN;
    logic                       writeStrobeN;
    logic                       dataPathSelectN;
    logic                       addrQualifier;
    logic                       cycleDirection;
    logic                       readyReturnN;
    logic                       localBusModeStrapN;
    logic [`LANE_W-1:0]         byteLaneEnablesN;
    logic [`UPPER_ADDR_W-1:0]   upperAddrLines;
  } pins_t;

  typedef enum logic [1:0] {
    SYNC_IDLE,
    SYNC_LB_ARM,
    SYNC_LB_DONE,
    SYNC_BURST_WAIT
  } sync_state_t;

  // ****************************************************************
  // whole state of the top module
  // ****************************************************************
  typedef struct packed {
    pins_t                      prev;
    logic                       strapTaken;
    logic                       localBusMode;
    sync_state_t                st;
    logic                       syncWrite;
    logic                       syncReadyN;
    logic                       burstDone;
    logic                       asyncReadyOe;
    logic                       hostIrq;
    logic [`UPPER_ADDR_W-1:0]   latchedAddr;
    logic                       latchedQual;
    logic                       regHit;
    logic                       dataGrant;
    logic [`LANE_W-1:0]         laneEnablesN;
  } state_t;

endpackage : host_bus_ready_decode_pkg

//--- logic/pin_sync.sv
// Purpose: two-stage synchroniser for a bundle of pins
// Assumes: each bit is a level; multi-bit words are only used once settled
// Notes: first stage feeds only the second; no reset, so the stages fill while reset is held
`timescale 1ns/1ns

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t stage_ff;
  sync_t nxt_stage;

  always_comb begin
    nxt_stage.meta   = din;
    nxt_stage.stable = stage_ff.meta;
  end

  // a reset here would show zeros for two edges after release: false edges, wrong strap
  always_ff @(posedge clk) begin
    stage_ff <= nxt_stage;
  end

  assign dout = stage_ff.stable;

endmodule : pin_sync

//--- logic/host_bus_ready_decode.sv
// Purpose: host bus ready, wait, select decode and interrupt for the packet controller
// Assumes: clk is the internal oscillator clock; bus pins are asynchronous to it
// Notes: local-device hit is a pure gate path on the raw pins
`timescale 1ns/1ns
`include "host_bus_ready_decode_regs.svh"

module host_bus_ready_decode #(
  parameter int FIFO_CNT_W = 4,
  parameter int EVENT_W    = 8
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     localBusModeStrapN,
  input  wire logic                     hostBusClock,
  input  wire logic                     readStrobeN,
  input  wire logic                     writeStrobeN,
  input  wire logic                     dataPathSelectN,
  input  wire logic                     addrQualifier,
  input  wire logic [`UPPER_ADDR_W-1:0] upperAddrLines,
  input  wire logic                     cycleDirection,
  input  wire logic [`LANE_W-1:0]       byteLaneEnablesN,
  input  wire logic                     addrLatchStrobeN,
  input  wire logic                     readyReturnN,
  input  wire logic                     noWaitBit,
  input  wire logic [`BASE_HI_W-1:0]    baseAddrHigh,
  input  wire logic [FIFO_CNT_W-1:0]    readFifoBytes,
  input  wire logic                     writeFifoFull,
  input  wire logic [EVENT_W-1:0]       statusEvents,
  input  wire logic [EVENT_W-1:0]       eventEnables,
  output logic                          asyncReadyOdOut,
  output logic                          asyncReadyOdOe,
  output logic                          syncReadyN,
  output logic                          syncCycleWrite,
  output logic                          burstReadDone,
  output logic                          hostIrq,
  output logic                          localDeviceHitN,
  output logic                          registerHit,
  output logic [`UPPER_ADDR_W-1:0]      latchedAddr,
  output logic                          dataPathGrant,
  output logic [`LANE_W-1:0]            effLaneEnablesN,
  output logic                          localBusModeOut
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  host_bus_ready_decode_pkg::pins_t rawPins;
  host_bus_ready_decode_pkg::pins_t pins;
  host_bus_ready_decode_pkg::state_t s_ff;
  host_bus_ready_decode_pkg::state_t nxt_s;

  logic hostRise;
  logic hostFall;
  logic strobeRise;
  logic asyncRead;
  logic asyncWrite;
  logic asyncWait;
  logic syncStart;
  logic baseMatch;

  always_comb begin
    rawPins.addrLatchStrobeN   = addrLatchStrobeN;
    rawPins.hostBusClock       = hostBusClock;
    rawPins.readStrobeN        = readStrobeN;
    rawPins.writeStrobeN       = writeStrobeN;
    rawPins.dataPathSelectN    = dataPathSelectN;
    rawPins.addrQualifier      = addrQualifier;
    rawPins.cycleDirection     = cycleDirection;
    rawPins.readyReturnN       = readyReturnN;
    rawPins.localBusModeStrapN = localBusModeStrapN;
    rawPins.byteLaneEnablesN   = byteLaneEnablesN;
    rawPins.upperAddrLines     = upperAddrLines;
  end

  pin_sync #(
    .WIDTH ($bits(host_bus_ready_decode_pkg::pins_t))
  ) u_pin_sync (
    .clk  (clk),
    .din  (rawPins),
    .dout (pins)
  );

  // ****************************************************************
  // edge detection and cycle qualification
  // ****************************************************************
  // bus clock is sampled, so edges are seen one to two clk periods late
  assign hostRise   = pins.hostBusClock & ~s_ff.prev.hostBusClock;
  assign hostFall   = ~pins.hostBusClock & s_ff.prev.hostBusClock;
  assign strobeRise = pins.addrLatchStrobeN & ~s_ff.prev.addrLatchStrobeN;
  assign asyncRead  = ~pins.readStrobeN;
  assign asyncWrite = ~pins.writeStrobeN;
  // async wait ignores the strap on purpose
  assign asyncWait  = (asyncRead | asyncWrite) & (~noWaitBit
                    | (asyncRead & (readFifoBytes < FIFO_CNT_W'(`RD_FIFO_MIN_BYTES)))
                    | (asyncWrite & writeFifoFull));
  assign syncStart  = strobeRise & pins.readStrobeN & pins.writeStrobeN;
  assign baseMatch  = upperAddrLines[`BASE_MATCH_HI:`BASE_MATCH_LO] == baseAddrHigh;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.prev      = pins;
    nxt_s.burstDone = 1'b0;
    // strap caught once after reset release, never under reset itself
    if (!s_ff.strapTaken) begin
      nxt_s.strapTaken   = 1'b1;
      nxt_s.localBusMode = ~pins.localBusModeStrapN;
    end
    // release is decided on clk, not on the host clock
    nxt_s.asyncReadyOe = asyncWait;
    nxt_s.hostIrq      = |(statusEvents & eventEnables);
    if (strobeRise) begin
      nxt_s.latchedAddr = pins.upperAddrLines;
      nxt_s.latchedQual = pins.addrQualifier;
    end
    nxt_s.regHit = ~nxt_s.latchedQual
                 & (nxt_s.latchedAddr[`BASE_MATCH_HI:`BASE_MATCH_LO] == baseAddrHigh);
    nxt_s.dataGrant = ~pins.dataPathSelectN;
    nxt_s.laneEnablesN = pins.dataPathSelectN ? pins.byteLaneEnablesN
                                              : `LANES_ALL_ON_N;
    case (s_ff.st)
      host_bus_ready_decode_pkg::SYNC_IDLE: begin
        if (syncStart && s_ff.strapTaken) begin
          nxt_s.syncWrite = pins.cycleDirection;
          if (s_ff.localBusMode) begin
            nxt_s.st = host_bus_ready_decode_pkg::SYNC_LB_ARM;
          end else if (!pins.cycleDirection) begin
            nxt_s.st = host_bus_ready_decode_pkg::SYNC_BURST_WAIT;
          end
        end
      end
      host_bus_ready_decode_pkg::SYNC_LB_ARM: begin
        if (hostRise) begin
          nxt_s.syncReadyN = 1'b0;
          nxt_s.st         = host_bus_ready_decode_pkg::SYNC_LB_DONE;
        end
      end
      host_bus_ready_decode_pkg::SYNC_LB_DONE: begin
        if (hostRise) begin
          nxt_s.syncReadyN = `SRDY_N_RST;
          nxt_s.st         = host_bus_ready_decode_pkg::SYNC_IDLE;
        end
      end
      host_bus_ready_decode_pkg::SYNC_BURST_WAIT: begin
        if (hostFall && pins.readyReturnN) begin
          nxt_s.burstDone = 1'b1;
          nxt_s.st        = host_bus_ready_decode_pkg::SYNC_IDLE;
        end
      end
      default: begin
        nxt_s.st         = host_bus_ready_decode_pkg::SYNC_IDLE;
        nxt_s.syncReadyN = `SRDY_N_RST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff              <= '0;
      s_ff.syncReadyN   <= `SRDY_N_RST;
      s_ff.latchedAddr  <= `ADDR_RST;
      s_ff.latchedQual  <= 1'b1;
      s_ff.laneEnablesN <= `LANES_RST_N;
      s_ff.prev.addrLatchStrobeN <= 1'b1;
      // bus clock idles high, so no false rise after release
      s_ff.prev.hostBusClock     <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // open drain: only ever pulls low, the board pull-up gives ready
  assign asyncReadyOdOut = `OD_LOW_LEVEL;
  assign asyncReadyOdOe  = s_ff.asyncReadyOe;
  assign syncReadyN      = s_ff.syncReadyN;
  assign syncCycleWrite  = s_ff.syncWrite;
  assign burstReadDone   = s_ff.burstDone;
  assign hostIrq         = s_ff.hostIrq;
  // no flip-flop here: the host needs the decode before its strobe
  assign localDeviceHitN = ~(~addrQualifier & baseMatch);
  assign registerHit     = s_ff.regHit;
  assign latchedAddr     = s_ff.latchedAddr;
  assign dataPathGrant   = s_ff.dataGrant;
  assign effLaneEnablesN = s_ff.laneEnablesN;
  assign localBusModeOut = s_ff.localBusMode;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  strap_mode_a: assert property ($rose(s_ff.strapTaken)
    |-> s_ff.localBusMode == ~$past(pins.localBusModeStrapN) ##1 $stable(s_ff.localBusMode))
    else $error("mode does not follow strap");
  nowait_hold_a: assert property ((asyncRead | asyncWrite) && !noWaitBit
    |=> asyncReadyOdOe) else $error("ready not held with no-wait cleared");
  rdfifo_wait_a: assert property (asyncRead && readFifoBytes < FIFO_CNT_W'(`RD_FIFO_MIN_BYTES)
    |=> asyncReadyOdOe) else $error("read ready with short fifo");
  wrfull_wait_a: assert property (asyncWrite && writeFifoFull
    |=> asyncReadyOdOe) else $error("write ready with full fifo");
  async_ready_od_release_a: assert property (!asyncRead && !asyncWrite
    |=> !asyncReadyOdOe) else $error("ready not released on clk");
  srdy_mode_a: assert property ($fell(syncReadyN)
    |-> localBusModeOut && $past(hostRise) ##1 !syncReadyN)
    else $error("sync ready fell out of place");
  srdy_burst_a: assert property (!localBusModeOut && s_ff.strapTaken
    |-> syncReadyN) else $error("sync ready driven in burst mode");
  burst_wait_a: assert property (burstReadDone
    |-> $past(hostFall) && $past(pins.readyReturnN) && !localBusModeOut)
    else $error("burst read done without ready-return high");
  irq_follow_a: assert property (|(statusEvents & eventEnables)
    |=> hostIrq) else $error("interrupt missed");
  addr_latch_a: assert property (strobeRise
    |=> latchedAddr == $past(pins.upperAddrLines)) else $error("address not latched");
  decode_gate_a: assert property (s_ff.latchedQual |-> !registerHit)
    else $error("decode with qualifier high");
  grant_lanes_a: assert property (!pins.dataPathSelectN
    |=> dataPathGrant && effLaneEnablesN == `LANES_ALL_ON_N)
    else $error("data path not granted");
  sync_dir_a: assert property (syncStart && s_ff.strapTaken && s_ff.st == host_bus_ready_decode_pkg::SYNC_IDLE
    |=> syncCycleWrite == $past(pins.cycleDirection)) else $error("direction not taken");

  lb_complete_c: cover property ($rose(syncReadyN) && localBusModeOut);
  burst_read_c: cover property (burstReadDone);
  async_wait_c: cover property (asyncRead ##1 asyncReadyOdOe ##1 !asyncReadyOdOe);
  grant_c: cover property ($rose(dataPathGrant));

endmodule : host_bus_ready_decode

//--- testbench/host_bus_model.sv
// Purpose: host side of the synchronous bus: bus clock and ready-return
// Assumes: run is raised only while a synchronous cycle is in flight
// Notes: slow holds ready-return low for the first three clock falls
`timescale 1ns/1ns

module host_bus_model (
  input  wire logic run,
  input  wire logic slow,
  output logic      hostBusClock,
  output logic      readyReturnN
);
  int falls;

  // ****
  // clock stands high between cycles, as the async mode wants
  // ****
  initial begin
    hostBusClock = 1'b1;
    readyReturnN = 1'b1;
    falls = 0;
    forever begin
      #80;
      if (run) begin
        hostBusClock = ~hostBusClock;
        if (hostBusClock) begin
          // change on the rise so the level is stable at every fall
          readyReturnN = !(slow && falls < 3);
        end else begin
          falls++;
        end
      end else begin
        hostBusClock = 1'b1;
        readyReturnN = !slow;
        falls = 0;
      end
    end
  end
endmodule : host_bus_model

//--- testbench/tb_host_bus_ready_decode.sv
// Purpose: self-checking bench of the host bus ready and decode block
// Assumes: bus clock from the host model at 160 ns period
// Notes: strap is only taken after reset, so both modes need a reset
`timescale 1ns/1ns
`include "host_bus_ready_decode_regs.svh"

module tb_host_bus_ready_decode;
  logic                     clk, nrst, strapN, run, slow, hbc, rrN;
  logic                     rdN, wrN, dpsN, qual, dir, alsN, noWait, wFull;
  logic [`UPPER_ADDR_W-1:0] addr;
  logic [`LANE_W-1:0]       lanesN;
  logic [`BASE_HI_W-1:0]    base;
  logic [3:0]               rBytes;
  logic [7:0]               ev, en;
  logic                     odOut, odOe, srN, sWr, bDone, irq, hitN, regHit, grant, lbm;
  logic [`UPPER_ADDR_W-1:0] lAddr;
  logic [`LANE_W-1:0]       effN;
  logic [31:0]              seed = 32'hfaf4;
  logic [31:0]              r;
  int                       nMismatch = 0, checksDone = 0, cycles = 0, n;

  host_bus_model hm (.run(run), .slow(slow), .hostBusClock(hbc), .readyReturnN(rrN));

  host_bus_ready_decode DUT (
    .clk(clk), .nrst(nrst), .localBusModeStrapN(strapN), .hostBusClock(hbc),
    .readStrobeN(rdN), .writeStrobeN(wrN), .dataPathSelectN(dpsN),
    .addrQualifier(qual), .upperAddrLines(addr), .cycleDirection(dir),
    .byteLaneEnablesN(lanesN), .addrLatchStrobeN(alsN), .readyReturnN(rrN),
    .noWaitBit(noWait), .baseAddrHigh(base), .readFifoBytes(rBytes),
    .writeFifoFull(wFull), .statusEvents(ev), .eventEnables(en),
    .asyncReadyOdOut(odOut), .asyncReadyOdOe(odOe), .syncReadyN(srN),
    .syncCycleWrite(sWr), .burstReadDone(bDone), .hostIrq(irq),
    .localDeviceHitN(hitN), .registerHit(regHit), .latchedAddr(lAddr),
    .dataPathGrant(grant), .effLaneEnablesN(effN), .localBusModeOut(lbm));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic expWait(input logic wr, nw, full, input logic [3:0] b);
    return !nw || (wr ? full : (b < `RD_FIFO_MIN_BYTES));
  endfunction : expWait

  function automatic logic expHit(input logic [11:0] a, input logic [7:0] bh, input logic q);
    return !(!q && a[11:4] == bh);
  endfunction : expHit

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : testDone

  task automatic doReset(input logic s);
    nrst <= 1'b0;
    strapN <= s;
    slow <= s;
    cyc(8);
    nrst <= 1'b1;
    cyc(3);
    chk({srN, odOut}, 16'h2);
    chk(lbm, !s);
  endtask : doReset

  task automatic waitOut(input logic sel, input logic v, output int k);
    k = 0;
    while (((sel ? bDone : srN) !== v) && k < 300) begin
      cyc(1);
      k++;
    end
    chk(k < 300, 1'b1);
  endtask : waitOut

  // strap must not change async waiting, so this runs in both modes
  task automatic asyncChk(input logic wr);
    for (int i = 0; i < 6; i++) begin
      rBytes <= 4'(i);
      wFull <= i[0];
      noWait <= (i != 5);
      rdN <= wr;
      wrN <= !wr;
      cyc(6);
      chk(odOe, expWait(wr, noWait, wFull, rBytes));
    end
    rdN <= 1'b1;
    wrN <= 1'b1;
    noWait <= 1'b1;
    cyc(5);
    chk(odOe, 1'b0);
  endtask : asyncChk

  task automatic syncCyc(input logic d);
    r = rnd();
    addr <= r[11:0];
    base <= r[11:4];
    qual <= 1'b0;
    dir <= d;
    alsN <= 1'b0;
    cyc(4);
    // address and direction stay put across the strobe rise
    alsN <= 1'b1;
    cyc(4);
    addr <= ~r[11:0];
    dir <= !d;
    cyc(4);
    chk(lAddr, r[11:0]);
    chk(regHit, 1'b1);
    chk(sWr, d);
    run <= 1'b1;
  endtask : syncCyc

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      testDone();
    end
  end

  initial begin
    {nrst, strapN, run, slow, qual, dir, ev, en} = '0;
    {rdN, wrN, dpsN, alsN, noWait} = 5'h1f;
    {wFull, rBytes, addr, base} = '0;
    lanesN = 4'hf;
    doReset(1'b0);
    // ****
    // decode, interrupt and data path under random pins
    // ****
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      r = rnd();
      addr <= r[11:0];
      base <= i[0] ? r[11:4] : r[19:12];
      qual <= i[1] & i[2];
      ev <= r[27:20];
      en <= r[31:24];
      dpsN <= r[3];
      lanesN <= r[7:4];
      #1;
      chk(hitN, expHit(addr, base, qual));
      cyc(4);
      chk(irq, |(ev & en));
      chk(grant, !dpsN);
      if (!dpsN) chk(effN, `LANES_ALL_ON_N);
    end
    dpsN <= 1'b1;
    $display("decode test done");
    asyncChk(1'b0);
    asyncChk(1'b1);
    // local-bus cycles: one read, one write
    for (int d = 0; d < 2; d++) begin
      syncCyc(d[0]);
      waitOut(1'b0, 1'b0, n);
      waitOut(1'b0, 1'b1, n);
      chk(n >= 6 && n <= 10, 1'b1);
      run <= 1'b0;
      cyc(4);
    end
    $display("local bus test done");
    doReset(1'b1);
    asyncChk(1'b0);
    syncCyc(1'b0);
    waitOut(1'b1, 1'b1, n);
    chk(rrN, 1'b1);
    chk(srN, 1'b1);
    chk(n >= 24, 1'b1);
    run <= 1'b0;
    cyc(4);
    $display("burst test done");
    testDone();
  end
endmodule : tb_host_bus_ready_decode
